// ==== core/dcp_regs.vh ====
// timing constants and state codes for the dc output protector controller
`ifndef DCP_REGS_VH
`define DCP_REGS_VH
`define DCP_CLK_HZ 40000000
`define DCP_RST_MIN_MS 500
`define DCP_RST_CYC ((`DCP_CLK_HZ / 1000) * `DCP_RST_MIN_MS)
`define DCP_COOL_MS 500
`define DCP_COOL_CYC ((`DCP_CLK_HZ / 1000) * `DCP_COOL_MS)
`define DCP_SEQ_MAX_MS 5000
`define DCP_SEQ_CYC ((`DCP_CLK_HZ / 1000) * `DCP_SEQ_MAX_MS)
`define DCP_TRIP_MIN_MS 250
`define DCP_TRIP_CYC ((`DCP_CLK_HZ / 1000) * `DCP_TRIP_MIN_MS)
`define DCP_DEB_CYC 400000
`define DCP_TICK_CYC 4000000
`define DCP_CODE_OFF 3'h0
`define DCP_CODE_ON 3'h1
`define DCP_CODE_OC 3'h2
`define DCP_CODE_MAN 3'h3
`define DCP_CODE_TNR 3'h4
`define DCP_CODE_TR 3'h5
`define DCP_CODE_ERR 3'h6
`define DCP_CODE_NONE 3'h7
`endif

// ==== core/dcp_ctrl.v ====
// control state machine of a multi-channel dc output protector
`timescale 1ns/100ps
`default_nettype none
`include "dcp_regs.vh"
module dcp_ctrl #(
    parameter NCH = 4,
    parameter OV_EN = 1,
    parameter RST_CYC = `DCP_RST_CYC,
    parameter COOL_CYC = `DCP_COOL_CYC,
    parameter SEQ_CYC = `DCP_SEQ_CYC,
    parameter TRIP_CYC = `DCP_TRIP_CYC,
    parameter DEB_CYC = `DCP_DEB_CYC,
    parameter TICK_CYC = `DCP_TICK_CYC
) (
    input wire REF_CLK, // 40 MHz clock
    input wire NRST, // async active-low reset
    input wire [NCH-1:0] OC_WARN, // current above rated level
    input wire [NCH-1:0] OC_HARD, // heavy overload, trip at shortest time
    input wire [NCH-1:0] OUT_SETTLED, // channel output has settled after enable
    input wire [NCH-1:0] FUSE_BLOWN, // internal fuse blown
    input wire MEM_ERR, // state memory error
    input wire OV_DET, // supply above over-voltage limit
    input wire RESET_IN, // external reset level
    input wire [NCH-1:0] BUTTON, // raw push buttons, high pressed
    input wire MEM_VALID, // stored states present
    input wire [3*NCH-1:0] MEM_STATE, // stored state codes
    input wire INIT_DONE, // initialization complete
    output reg [NCH-1:0] SW_EN, // output switch enables
    output reg [NCH-1:0] LED_RED, // indicator red
    output reg [NCH-1:0] LED_GRN, // indicator green
    output reg [3*NCH-1:0] SAVE_STATE, // states to store on power loss
    output reg FAULT_RELAY_A // relay conducts when high
);
    localparam S_INIT = 8'h01;
    localparam S_WAIT = 8'h02;
    localparam S_ON = 8'h04;
    localparam S_OC = 8'h08;
    localparam S_MAN = 8'h10;
    localparam S_TNR = 8'h20;
    localparam S_TR = 8'h40;
    localparam S_ERR = 8'h80;

    reg rs1_r, rs2_r;
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end
    wire rst_n = rs2_r;

    // time base for the blink phases only; the reset, sequence, trip and debounce timers count clock cycles directly
    reg [31:0] tick_cnt_r;
    reg [2:0] blink_r;
    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= 32'h0;
            blink_r <= 3'h0;
        end else if (tick_cnt_r >= TICK_CYC - 1) begin
            tick_cnt_r <= 32'h0;
            blink_r <= blink_r + 3'h1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end
    wire fast_ph = blink_r[0];
    wire slow_ph = blink_r[2];

    // reset-input width timer; one pulse per long-enough high level
    reg [31:0] rst_cnt_r;
    reg rst_fire_r;
    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_r <= 32'h0;
            rst_fire_r <= 1'b0;
        end else begin
            rst_fire_r <= 1'b0;
            if (!RESET_IN) begin
                rst_cnt_r <= 32'h0;
            end else if (rst_cnt_r < RST_CYC) begin
                rst_cnt_r <= rst_cnt_r + 32'h1;
                if (rst_cnt_r == RST_CYC - 1)
                    rst_fire_r <= 1'b1;
            end
        end
    end

    // start-up sequencer: one channel enabled at a time
    reg [NCH:0] seq_r;
    reg [31:0] seq_cnt_r;
    wire ov_act = (OV_EN != 0) && OV_DET;
    wire [NCH-1:0] go;
    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            seq_r <= {(NCH+1){1'b0}};
            seq_cnt_r <= 32'h0;
        end else if (!INIT_DONE) begin
            seq_r <= {(NCH+1){1'b0}};
            seq_cnt_r <= 32'h0;
        end else if (seq_r[NCH:0] == {(NCH+1){1'b0}}) begin
            seq_r <= {{NCH{1'b0}}, 1'b1};
            seq_cnt_r <= 32'h0;
        end else if (!seq_r[NCH]) begin
            if ((|(seq_r[NCH-1:0] & OUT_SETTLED)) || seq_cnt_r >= SEQ_CYC - 1) begin
                seq_r <= {seq_r[NCH-1:0], 1'b0};
                seq_cnt_r <= 32'h0;
            end else begin
                seq_cnt_r <= seq_cnt_r + 32'h1;
            end
        end
    end
    assign go = seq_r[NCH-1:0];

    wire [NCH-1:0] relay_ok;
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : ch
            reg [7:0] st_r, st_nxt;
            reg [31:0] cnt_r;
            reg [31:0] deb_r;
            reg btn_r, btn_d_r;
            wire press = btn_r && !btn_d_r;
            wire [2:0] stored = MEM_STATE[3*g+2:3*g];
            wire err = FUSE_BLOWN[g] || MEM_ERR;
            // debounce: level accepted only after DEB_CYC stable cycles
            always @(posedge REF_CLK or negedge rst_n) begin
                if (!rst_n) begin
                    deb_r <= 32'h0;
                    btn_r <= 1'b0;
                    btn_d_r <= 1'b0;
                end else begin
                    btn_d_r <= btn_r;
                    if (BUTTON[g] == btn_r)
                        deb_r <= 32'h0;
                    else if (deb_r >= DEB_CYC - 1) begin
                        btn_r <= BUTTON[g];
                        deb_r <= 32'h0;
                    end else
                        deb_r <= deb_r + 32'h1;
                end
            end
            // heavy overload trips at the short end of the window, others at the long end
            wire trip_due = OC_HARD[g] ? (cnt_r >= TRIP_CYC - 1) : (cnt_r >= SEQ_CYC - 1);
            always @* begin
                st_nxt = st_r;
                case (st_r)
                    S_INIT: begin
                        if (INIT_DONE) begin
                            st_nxt = S_WAIT;
                        end
                    end
                    S_WAIT: begin
                        // a channel waits for its turn in the start-up sequence
                        if (go[g] && !MEM_VALID) begin
                            st_nxt = S_ON;
                        end else if (go[g]) begin
                            case (stored)
                                `DCP_CODE_MAN: st_nxt = S_MAN;
                                `DCP_CODE_TNR: st_nxt = S_TNR;
                                `DCP_CODE_TR: st_nxt = S_TR;
                                default: st_nxt = S_ON;
                            endcase
                        end
                    end
                    S_ON: begin
                        if (press) begin
                            st_nxt = S_MAN;
                        end else if (OC_WARN[g]) begin
                            st_nxt = S_OC;
                        end
                    end
                    S_OC: begin
                        if (press) begin
                            st_nxt = S_MAN;
                        end else if (trip_due) begin
                            st_nxt = S_TNR;
                        end else if (!OC_WARN[g]) begin
                            st_nxt = S_ON;
                        end
                    end
                    S_MAN: begin
                        if (press) begin
                            st_nxt = S_ON;
                        end
                    end
                    S_TNR: begin
                        // button and reset are deliberately not looked at while cooling
                        if (cnt_r >= COOL_CYC - 1) begin
                            st_nxt = S_TR;
                        end
                    end
                    S_TR: begin
                        if (press) begin
                            st_nxt = S_MAN;
                        end else if (rst_fire_r) begin
                            st_nxt = S_ON;
                        end
                    end
                    S_ERR: begin
                        st_nxt = S_ERR;
                    end
                    default: begin
                        st_nxt = S_INIT;
                    end
                endcase
                if (err && st_r != S_INIT) begin
                    st_nxt = S_ERR;
                end
            end
            always @(posedge REF_CLK or negedge rst_n) begin
                if (!rst_n) begin
                    st_r <= S_INIT;
                    cnt_r <= 32'h0;
                end else if (!ov_act || st_r == S_INIT || st_r == S_WAIT
                             || st_nxt == S_ERR) begin
                    // over-voltage freezes state so recovery returns to it
                    st_r <= st_nxt;
                    cnt_r <= (st_nxt != st_r) ? 32'h0 : cnt_r + 32'h1;
                end
            end
            wire run = !ov_act;
            wire sw_nxt = run && (st_r == S_ON || st_r == S_OC);
            reg red, grn;
            always @* begin
                red = 1'b0;
                grn = 1'b0;
                if (st_r == S_ERR || (ov_act && st_r != S_INIT && st_r != S_WAIT)) begin
                    red = fast_ph;
                end else begin
                    case (st_r)
                        S_ON: grn = 1'b1;
                        S_OC: begin
                            red = 1'b1;
                            grn = 1'b1;
                        end
                        S_MAN: red = 1'b1;
                        S_TNR: red = slow_ph;
                        S_TR: begin
                            red = slow_ph;
                            grn = slow_ph;
                        end
                        default: begin
                            red = 1'b0;
                            grn = 1'b0;
                        end
                    endcase
                end
            end
            always @(posedge REF_CLK or negedge rst_n) begin
                if (!rst_n) begin
                    SW_EN[g] <= 1'b0;
                    LED_RED[g] <= 1'b0;
                    LED_GRN[g] <= 1'b0;
                    SAVE_STATE[3*g+2:3*g] <= `DCP_CODE_NONE;
                end else begin
                    SW_EN[g] <= sw_nxt;
                    LED_RED[g] <= red;
                    LED_GRN[g] <= grn;
                    case (st_r)
                        S_ON: SAVE_STATE[3*g+2:3*g] <= `DCP_CODE_ON;
                        S_OC: SAVE_STATE[3*g+2:3*g] <= `DCP_CODE_OC;
                        S_MAN: SAVE_STATE[3*g+2:3*g] <= `DCP_CODE_MAN;
                        S_TNR: SAVE_STATE[3*g+2:3*g] <= `DCP_CODE_TNR;
                        S_TR: SAVE_STATE[3*g+2:3*g] <= `DCP_CODE_TR;
                        S_ERR: SAVE_STATE[3*g+2:3*g] <= `DCP_CODE_ERR;
                        default: SAVE_STATE[3*g+2:3*g] <= SAVE_STATE[3*g+2:3*g];
                    endcase
                end
            end
            assign relay_ok[g] = run && (st_r == S_ON || st_r == S_OC);
        end
    endgenerate

    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n)
            FAULT_RELAY_A <= 1'b0;
        else
            FAULT_RELAY_A <= &relay_ok;
    end
endmodule // dcp_ctrl
`default_nettype wire

// ==== tb/dcp_ctrl_assertions.sv ====
// concurrent checks on the protector controller ports
`timescale 1ns/100ps
`default_nettype none
`include "dcp_regs.vh"
module dcp_ctrl_assertions #(
    parameter NCH = 4,
    parameter OV_EN = 1,
    parameter COOL_CYC = 40
) (
    input wire REF_CLK, // clock
    input wire NRST, // async reset, active low
    input wire [NCH-1:0] FUSE_BLOWN, // fuse flags
    input wire MEM_ERR, // memory error
    input wire OV_DET, // supply over limit
    input wire RESET_IN, // external reset level
    input wire INIT_DONE, // initialization done
    input wire [NCH-1:0] SW_EN, // switch enables
    input wire [NCH-1:0] LED_RED, // red indicators
    input wire [NCH-1:0] LED_GRN, // green indicators
    input wire [3*NCH-1:0] SAVE_STATE, // state codes
    input wire FAULT_RELAY_A // relay conducting
);
    logic [31:0] tnr_cnt_r;
    wire [2:0] st0 = SAVE_STATE[2:0];
    // counts how long channel 0 has sat in the non-resettable trip
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            tnr_cnt_r <= 32'h0;
        end else if (st0 == `DCP_CODE_TNR) begin
            tnr_cnt_r <= tnr_cnt_r + 32'h1;
        end else begin
            tnr_cnt_r <= 32'h0;
        end
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    a_relay_needs_all: assert property (FAULT_RELAY_A |-> &SW_EN)
        else $error("relay conducts with a switch open");
    a_ov_opens_all: assert property ((OV_DET && OV_EN != 0) [*4] |-> SW_EN == '0 && !FAULT_RELAY_A)
        else $error("over-voltage left a switch closed");
    a_fuse_opens_ch: assert property (FUSE_BLOWN[0] [*4] |-> !SW_EN[0] && !FAULT_RELAY_A)
        else $error("blown fuse left channel closed");
    a_mem_err_opens: assert property (MEM_ERR [*4] |-> SW_EN == '0 && !FAULT_RELAY_A)
        else $error("memory error left a switch closed");
    a_tnr_holds_state: assert property (st0 == `DCP_CODE_TNR |=> st0 inside {`DCP_CODE_TNR,
        `DCP_CODE_TR, `DCP_CODE_ERR})
        else $error("non-resettable trip left early");
    a_tr_on_by_reset: assert property ($past(st0) == `DCP_CODE_TR && st0 == `DCP_CODE_ON
        |-> $past(RESET_IN) || $past(RESET_IN, 2) || $past(RESET_IN, 3))
        else $error("trip cleared without reset");
    a_green_means_on: assert property (LED_GRN[0] && !LED_RED[0] |-> SW_EN[0])
        else $error("green shown with switch open");
    a_init_dark: assert property (!INIT_DONE |-> SW_EN == '0 && LED_RED == '0 && LED_GRN == '0)
        else $error("outputs active during initialization");
    a_cool_time: assert property ($past(st0) == `DCP_CODE_TNR && st0 == `DCP_CODE_TR
        |-> tnr_cnt_r + 3 >= COOL_CYC && tnr_cnt_r <= COOL_CYC + 3)
        else $error("cooling interval length wrong");
endmodule // dcp_ctrl_assertions
bind dcp_ctrl dcp_ctrl_assertions #(.NCH(NCH), .OV_EN(OV_EN), .COOL_CYC(COOL_CYC)) chk_u (
    .REF_CLK(REF_CLK), .NRST(NRST), .FUSE_BLOWN(FUSE_BLOWN), .MEM_ERR(MEM_ERR),
    .OV_DET(OV_DET), .RESET_IN(RESET_IN), .INIT_DONE(INIT_DONE), .SW_EN(SW_EN),
    .LED_RED(LED_RED), .LED_GRN(LED_GRN), .SAVE_STATE(SAVE_STATE), .FAULT_RELAY_A(FAULT_RELAY_A));
`default_nettype wire

// ==== tb/dcp_ext_ctl.sv ====
// outside controller model that drives the reset level input
`timescale 1ns/100ps
`default_nettype none
module dcp_ext_ctl (
    input wire logic clk, // bench clock
    input wire logic go, // start one reset request
    input wire logic [7:0] len, // high time is len+1 cycles
    output logic rst_line, // reset level to the block
    output logic busy // request in progress
);
    logic [7:0] cnt_r;
    initial begin
        rst_line = 1'b0;
        busy = 1'b0;
        cnt_r = 8'h0;
    end
    // the level is held for the full count, then dropped to leave a gap
    always @(posedge clk) begin
        if (go && !busy) begin
            cnt_r <= len;
            rst_line <= 1'b1;
            busy <= 1'b1;
        end else if (cnt_r != 8'h0) begin
            cnt_r <= cnt_r - 8'h1;
        end else begin
            rst_line <= 1'b0;
            busy <= 1'b0;
        end
    end
endmodule // dcp_ext_ctl
`default_nettype wire

// ==== tb/dc_output_protection_fsm_tb_top.sv ====
// self-checking bench for the protector controller
`timescale 1ns/100ps
`default_nettype none
`include "dcp_regs.vh"
module dc_output_protection_fsm_tb_top;
    localparam int RST = 20, COOL = 150, SEQ = 60, TRIP = 10, DEB = 3, TICK = 4;
    typedef struct packed {logic [3:0] sw; logic rly; logic [11:0] sav;
        logic [3:0] grn; logic [3:0] red; logic led;} dcp_exp_t;
    logic clk = 1'b0, nrst = 1'b0, mem_err = 1'b0, ov = 1'b0, init_done = 1'b0;
    logic mem_valid = 1'b0, go = 1'b0;
    logic [3:0] oc_warn = 4'h0, oc_hard = 4'h0, settled = 4'hF, fuse = 4'h0, button = 4'h0, es;
    logic [11:0] mem_state = 12'h0;
    logic [7:0] len = 8'h0;
    wire [3:0] sw, red, grn;
    wire [11:0] sav;
    wire relay, rst_line, busy;
    int err_count = 0, checks = 0;
    dcp_exp_t q[$];
    event chk_ev;
    always #12.5 clk = ~clk;
    dcp_ctrl #(.NCH(4), .OV_EN(1), .RST_CYC(RST), .COOL_CYC(COOL), .SEQ_CYC(SEQ),
        .TRIP_CYC(TRIP), .DEB_CYC(DEB), .TICK_CYC(TICK)) dut_u (
        .REF_CLK(clk), .NRST(nrst), .OC_WARN(oc_warn), .OC_HARD(oc_hard), .OUT_SETTLED(settled),
        .FUSE_BLOWN(fuse), .MEM_ERR(mem_err), .OV_DET(ov), .RESET_IN(rst_line), .BUTTON(button),
        .MEM_VALID(mem_valid), .MEM_STATE(mem_state), .INIT_DONE(init_done), .SW_EN(sw),
        .LED_RED(red), .LED_GRN(grn), .SAVE_STATE(sav), .FAULT_RELAY_A(relay));
    dcp_ext_ctl ext_u (.clk(clk), .go(go), .len(len), .rst_line(rst_line), .busy(busy));
    task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic expect_st(input logic [3:0] s, input logic r, input logic [11:0] v,
        input logic [3:0] g, input logic [3:0] d, input logic l);
        q.push_back({s, r, v, g, d, l});
        ->chk_ev;
    endtask
    function automatic logic [11:0] one(input int ch, input logic [2:0] c);
        logic [11:0] v;
        v = {4{`DCP_CODE_ON}};
        v[ch*3+:3] = c;
        return v;
    endfunction
    task automatic press(input int ch);
        button[ch] = 1'b1;
        cyc(20);
        button[ch] = 1'b0;
        cyc(20);
    endtask
    // hand the reset request to the outside controller model and wait it out
    task automatic pulse(input int n);
        len = 8'(n);
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(n + 6);
    endtask
    always @(chk_ev) begin : mon
        dcp_exp_t e;
        e = q.pop_front();
        check("switch", 12'(sw), 12'(e.sw));
        check("relay", 12'(relay), 12'(e.rly));
        check("state", sav, e.sav);
        if (e.led) begin
            check("green", 12'(grn), 12'(e.grn));
            check("red", 12'(red), 12'(e.red));
        end
    end
    initial begin
        #(25 * 20000);
        err_count++;
        print_verdict();
    end
    initial begin
        void'($urandom(74241));
        cyc(2);
        nrst = 1'b1;
        cyc(3);
        init_done = 1'b1;
        cyc(40);
        expect_st(4'hF, 1'b1, one(0, `DCP_CODE_ON), 4'hF, 4'h0, 1'b1);
        $display("test power-up default done");
        press(1);
        expect_st(4'hD, 1'b0, one(1, `DCP_CODE_MAN), 4'hD, 4'h2, 1'b1);
        press(1);
        expect_st(4'hF, 1'b1, one(0, `DCP_CODE_ON), 4'hF, 4'h0, 1'b1);
        $display("test button toggle done");
        oc_warn[0] = 1'b1;
        cyc(6);
        expect_st(4'hF, 1'b1, one(0, `DCP_CODE_OC), 4'hF, 4'h1, 1'b1);
        oc_hard[0] = 1'b1;
        cyc(TRIP + 6);
        oc_warn[0] = 1'b0;
        oc_hard[0] = 1'b0;
        expect_st(4'hE, 1'b0, one(0, `DCP_CODE_TNR), 4'hE, 4'h0, 1'b0);
        press(0);
        pulse(RST + 5);
        expect_st(4'hE, 1'b0, one(0, `DCP_CODE_TNR), 4'hE, 4'h0, 1'b0);
        cyc(COOL);
        expect_st(4'hE, 1'b0, one(0, `DCP_CODE_TR), 4'hE, 4'h0, 1'b0);
        pulse(5);
        expect_st(4'hE, 1'b0, one(0, `DCP_CODE_TR), 4'hE, 4'h0, 1'b0);
        press(1);
        pulse(RST + 5);
        expect_st(4'hD, 1'b0, one(1, `DCP_CODE_MAN), 4'hD, 4'h2, 1'b1);
        $display("test current trip done");
        ov = 1'b1;
        cyc(6);
        expect_st(4'h0, 1'b0, one(1, `DCP_CODE_MAN), 4'h0, 4'h0, 1'b0);
        ov = 1'b0;
        cyc(6);
        expect_st(4'hD, 1'b0, one(1, `DCP_CODE_MAN), 4'hD, 4'h2, 1'b1);
        $display("test over-voltage done");
        press(1);
        fuse[0] = 1'b1;
        cyc(6);
        expect_st(4'hE, 1'b0, one(0, `DCP_CODE_ERR), 4'hE, 4'h0, 1'b0);
        fuse[0] = 1'b0;
        mem_err = 1'b1;
        cyc(6);
        expect_st(4'h0, 1'b0, {4{`DCP_CODE_ERR}}, 4'h0, 4'h0, 1'b0);
        mem_err = 1'b0;
        $display("test internal error done");
        for (int i = 0; i < 4; i++) begin
            es[i] = 1'($urandom % 2);
            mem_state[i*3+:3] = es[i] ? `DCP_CODE_ON : `DCP_CODE_MAN;
        end
        mem_valid = 1'b1;
        nrst = 1'b0;
        init_done = 1'b0;
        cyc(2);
        nrst = 1'b1;
        cyc(4);
        init_done = 1'b1;
        cyc(40);
        expect_st(es, &es, mem_state, es, ~es, 1'b1);
        $display("test stored state restore done");
        print_verdict();
    end
endmodule // dc_output_protection_fsm_tb_top
`default_nettype wire
